/* verilog/pse_status_mode_pkg.sv */
/*
  Shared constants and types for the channel status and mode register group:
  command codes, field positions, reset values, mode and bus-state encodings,
  timing counts, the write struct passed between the two modules and the off-clear struct.
  Assumes a 50 MHz device clock and four channels per device.
*/
package pse_status_mode_pkg;

  // Geometry
  localparam int          NUM_CH          = 4;
  localparam int          MODE_FIELD_W    = 2;

  // Command codes of the register group
  localparam logic [7:0]  CMD_POWER_STATE = 8'h10;
  localparam logic [7:0]  CMD_STRAP_READ  = 8'h11;
  localparam logic [7:0]  CMD_MODE_SELECT = 8'h12;

  // Reset values
  localparam logic [7:0]  POWER_STATE_RST = 8'h00;
  localparam logic [7:0]  MODE_SELECT_RST = 8'h00;
  localparam logic [7:0]  STRAP_READ_RST  = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

  // Field positions
  localparam int          PG_LSB          = 4;
  localparam int          PE_LSB          = 0;
  localparam int          STRAP_LSB       = 3;
  localparam int          GROUP_BIT       = 2;

  // Target address: two fixed top bits, four straps, group bit
  localparam logic [1:0]  ADDR_TOP_BITS   = 2'h1;
  localparam logic [6:0]  BROADCAST_ADDR  = 7'h7F;

  // Value reloaded into a channel's policing register on entry to off
  localparam logic [7:0]  POLICING_RELOAD = 8'hFF;

  // Timing: off-entry clearing must finish within this time
  localparam int          CLK_PERIOD_NS        = 20;
  localparam int          OFF_CLEAR_MAX_MS     = 5;
  localparam int          OFF_CLEAR_MAX_CYCLES = (OFF_CLEAR_MAX_MS * 1000000) / CLK_PERIOD_NS;

  // Per-channel operating mode
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_SEMI   = 2'h2,
    MODE_AUTO   = 2'h3
  } chan_mode_t;

  // Off-entry clear sequencer states
  typedef enum logic [1:0] {
    CLR_IDLE   = 2'h1,
    CLR_STROBE = 2'h2
  } clr_state_t;

  // Serial target states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_CMD   = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK   = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK  = 7'h40
  } i2c_state_t;

  // Register write taken from the serial target
  typedef struct packed {
    logic       stb;
    logic [7:0] cmd;
    logic [7:0] data;
  } reg_write_t;

  // Clear request towards the per-channel registers outside this group
  typedef struct packed {
    logic [NUM_CH-1:0] mask;
    logic [7:0]        policing_value;
  } off_clear_t;

endpackage

/* verilog/i2c_cmd_target.sv */
/*
  Serial target for command-code register access: address byte, command byte,
  then data bytes written to that command, or a repeated start and read of it.
  Assumes SCL and SDA are already synchronous to i_clk and that SCL is slow
  against the clock (several clocks per level). SDA is open drain.
*/
`timescale 1ns/1ps

module i2c_cmd_target
  import pse_status_mode_pkg::*;
(
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_reset_n,
  // Serial pins
  input  wire logic  i_scl,
  input  wire logic  i_sda_in,
  output logic       o_sda_out,
  output logic       o_sda_oe,
  // Register side
  input  wire logic [6:0] i_dev_addr,
  input  wire logic [7:0] i_rd_data,
  output logic [7:0] o_rd_cmd,
  output reg_write_t o_wr
);

  i2c_state_t state_r;
  i2c_state_t after_ack_r;
  logic       scl_q_r;
  logic       sda_q_r;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic       got_byte_r;
  logic       nack_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       addr_hit;
  logic       wr_fire;

  // Previous line levels for edge and start/stop detection
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= i_scl;
      sda_q_r <= i_sda_in;
    end

  assign scl_rise   = i_scl & ~scl_q_r;
  assign scl_fall   = ~i_scl & scl_q_r;
  assign start_cond = i_scl & scl_q_r & sda_q_r & ~i_sda_in;
  assign stop_cond  = i_scl & scl_q_r & ~sda_q_r & i_sda_in;

  // Own address always; broadcast only for writes, so reads never collide
  assign addr_hit = (shift_r[7:1] == i_dev_addr) ||
                    ((shift_r[7:1] == BROADCAST_ADDR) && !shift_r[0]);
  assign wr_fire  = scl_fall && !start_cond && !stop_cond && (state_r == ST_WDATA) && got_byte_r;

  // Byte engine: shift in on SCL rise, drive SDA on SCL fall
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      state_r     <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      shift_r     <= 8'h00;
      bit_cnt_r   <= 3'h0;
      got_byte_r  <= 1'b0;
      nack_r      <= 1'b0;
      o_sda_oe    <= 1'b0;
      o_rd_cmd    <= 8'h00;
    end
    else if (start_cond)
    begin
      state_r    <= ST_ADDR;
      bit_cnt_r  <= 3'h0;
      got_byte_r <= 1'b0;
      o_sda_oe   <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_r  <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_r)
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          shift_r    <= {shift_r[6:0], i_sda_in};
          bit_cnt_r  <= bit_cnt_r + 3'h1;
          got_byte_r <= (bit_cnt_r == 3'h7);
        end
        ST_RACK: nack_r <= i_sda_in;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_r)
        ST_ADDR:
          if (got_byte_r)
          begin
            got_byte_r  <= 1'b0;
            o_sda_oe    <= addr_hit;
            state_r     <= addr_hit ? ST_ACK : ST_IDLE;
            after_ack_r <= shift_r[0] ? ST_RDATA : ST_CMD;
          end
        ST_CMD:
          if (got_byte_r)
          begin
            got_byte_r  <= 1'b0;
            o_rd_cmd    <= shift_r;
            o_sda_oe    <= 1'b1;
            state_r     <= ST_ACK;
            after_ack_r <= ST_WDATA;
          end
        ST_WDATA:
          if (got_byte_r)
          begin
            got_byte_r  <= 1'b0;
            o_sda_oe    <= 1'b1;
            state_r     <= ST_ACK;
            after_ack_r <= ST_WDATA;
          end
        ST_ACK, ST_RACK:
          if ((state_r == ST_RACK && nack_r) || (state_r == ST_ACK && after_ack_r != ST_RDATA))
          begin
            o_sda_oe  <= 1'b0;
            state_r   <= (state_r == ST_RACK) ? ST_IDLE : after_ack_r;
            bit_cnt_r <= 3'h0;
          end
          else
          begin
            // Read byte sampled here, so it reflects state at the moment of the read
            o_sda_oe  <= ~i_rd_data[7];
            shift_r   <= {i_rd_data[6:0], 1'b1};
            bit_cnt_r <= 3'h1;
            state_r   <= ST_RDATA;
          end
        ST_RDATA:
          if (bit_cnt_r == 3'h0)
          begin
            o_sda_oe <= 1'b0;
            state_r  <= ST_RACK;
          end
          else
          begin
            o_sda_oe  <= ~shift_r[7];
            shift_r   <= {shift_r[6:0], 1'b1};
            bit_cnt_r <= bit_cnt_r + 3'h1;
          end
        default: ;
      endcase
    end

  // One-cycle write strobe as the data byte is acknowledged
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_wr      <= '0;
      o_sda_out <= 1'b0;
    end
    else
    begin
      o_wr.stb  <= wr_fire;
      o_wr.cmd  <= o_rd_cmd;
      o_wr.data <= shift_r;
      o_sda_out <= 1'b0;  // Open drain: only ever pulls low
    end

endmodule

/* verilog/pse_channel_status_mode_regs.sv */
/*
  Channel power status, strap readback and operating mode registers for a
  four-channel power sourcing controller, reached over the serial command port.
  Assumes the power stage reports each channel's on state and drain level
  synchronously, and that the registers named in the off-entry clear live
  outside and obey o_off_clear.
*/
`timescale 1ns/1ps

module pse_channel_status_mode_regs
  import pse_status_mode_pkg::*;
#(
  parameter int OFF_CLEAR_LIMIT = OFF_CLEAR_MAX_CYCLES
)
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // Serial pins
  input  wire logic              i_scl,
  input  wire logic              i_sda_in,
  output logic                   o_sda_out,
  output logic                   o_sda_oe,
  // Straps, caught once after reset
  input  wire logic [3:0]        i_strap_pins,
  input  wire logic              i_group_select,
  input  wire logic              i_config_b,
  // Power stage status
  input  wire logic [NUM_CH-1:0] i_channel_on,
  input  wire logic [NUM_CH-1:0] i_turn_on_active,
  input  wire logic [NUM_CH-1:0] i_drain_below_pg,
  // Channel control and events
  output logic [7:0]             o_channel_mode,
  output logic [NUM_CH-1:0]      o_channel_active,
  output logic [NUM_CH-1:0]      o_power_good_flags,
  output logic [NUM_CH-1:0]      o_channel_on_flags,
  output logic [NUM_CH-1:0]      o_power_good_change_event,
  output logic [NUM_CH-1:0]      o_power_enable_change_event,
  output logic [NUM_CH-1:0]      o_cooldown_cancel,
  output off_clear_t             o_off_clear
);

  localparam int CLEAR_BOUND = 12;

  reg_write_t        wr;
  logic [7:0]        rd_cmd;
  logic [7:0]        rd_data;
  logic [7:0]        channel_mode_select_r;
  logic [7:0]        channel_power_state_r;
  logic [7:0]        address_strap_readback_r;
  logic              strap_caught_r;
  logic              mode_wr;
  logic [NUM_CH-1:0] off_mask;
  logic [NUM_CH-1:0] off_entry;
  logic [NUM_CH-1:0] cool_cancel;
  logic [NUM_CH-1:0] on_flags_nxt;
  logic [NUM_CH-1:0] pg_flags_nxt;
  logic [NUM_CH-1:0] pending_r;
  logic [NUM_CH-1:0] serve_oh;
  logic [NUM_CH-1:0] taken;
  clr_state_t        clr_state_r;
  logic [31:0]       pending_age_r;

  // Serial command port; address is built from the captured straps
  i2c_cmd_target u_target (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_scl      (i_scl),
    .i_sda_in   (i_sda_in),
    .o_sda_out  (o_sda_out),
    .o_sda_oe   (o_sda_oe),
    .i_dev_addr ({ADDR_TOP_BITS, address_strap_readback_r[STRAP_LSB +: 4],
                  address_strap_readback_r[GROUP_BIT]}),
    .i_rd_data  (rd_data),
    .o_rd_cmd   (rd_cmd),
    .o_wr       (wr)
  );

  // Read mux; unmapped commands read zero
  always_comb
  begin
    case (rd_cmd)
      CMD_POWER_STATE: rd_data = channel_power_state_r;
      CMD_STRAP_READ:  rd_data = address_strap_readback_r;
      CMD_MODE_SELECT: rd_data = channel_mode_select_r;
      default:         rd_data = READ_UNMAPPED;
    endcase
  end

  // Only the mode register takes writes; status and strap writes fall away
  assign mode_wr = wr.stb && (wr.cmd == CMD_MODE_SELECT);

  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      channel_mode_select_r <= MODE_SELECT_RST;
    else if (mode_wr)
      channel_mode_select_r <= wr.data;

  // Per-channel mode decode and transition detection
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    logic [1:0] old_f;
    logic [1:0] new_f;
    assign old_f           = channel_mode_select_r[ch*MODE_FIELD_W +: MODE_FIELD_W];
    assign new_f           = wr.data[ch*MODE_FIELD_W +: MODE_FIELD_W];
    assign off_mask[ch]    = (old_f == MODE_OFF);
    assign off_entry[ch]   = mode_wr && (old_f != MODE_OFF) && (new_f == MODE_OFF);
    assign cool_cancel[ch] = mode_wr && (old_f == MODE_SEMI) &&
                             ((new_f == MODE_MANUAL) || (new_f == MODE_OFF));
  end

  // Straps are sampled on the first edge after reset release, never at reset
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      address_strap_readback_r <= STRAP_READ_RST;
      strap_caught_r           <= 1'b0;
    end
    else if (!strap_caught_r)
    begin
      strap_caught_r           <= 1'b1;
      address_strap_readback_r <= {1'b0, i_strap_pins,
                                   i_group_select & ~i_config_b, 2'h0};
    end

  // Flags: on follows the stage but is forced off by off mode; power-good latches
  assign on_flags_nxt = i_channel_on & ~off_mask;
  assign pg_flags_nxt = on_flags_nxt &
                        (channel_power_state_r[PG_LSB +: NUM_CH] |
                         (i_turn_on_active & i_drain_below_pg));

  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      channel_power_state_r <= POWER_STATE_RST;
    else
      channel_power_state_r <= {pg_flags_nxt, on_flags_nxt};

  assign o_power_good_flags = channel_power_state_r[PG_LSB +: NUM_CH];
  assign o_channel_on_flags = channel_power_state_r[PE_LSB +: NUM_CH];

  // Falling-edge events, one-cycle pulses for the power event register
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_power_good_change_event   <= '0;
      o_power_enable_change_event <= '0;
    end
    else
    begin
      o_power_good_change_event   <= channel_power_state_r[PG_LSB +: NUM_CH] & ~pg_flags_nxt;
      o_power_enable_change_event <= channel_power_state_r[PE_LSB +: NUM_CH] & ~on_flags_nxt;
    end

  // Mode mirror, activity gate and cooldown cancel pulses
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_channel_mode    <= MODE_SELECT_RST;
      o_channel_active  <= '0;
      o_cooldown_cancel <= '0;
    end
    else
    begin
      o_channel_mode    <= channel_mode_select_r;
      o_channel_active  <= ~off_mask;
      o_cooldown_cancel <= cool_cancel;
    end

  // Pending clears; a new entry wins over the service of the same channel
  assign serve_oh = pending_r & (~pending_r + 4'h1);
  assign taken    = (clr_state_r == CLR_IDLE) ? serve_oh : '0;

  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      pending_r <= '0;
    else
      pending_r <= (pending_r & ~taken) | off_entry;

  // One channel per strobe, so the outside logic never sees two at once
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      clr_state_r <= CLR_IDLE;
      o_off_clear <= '0;
    end
    else
    begin
      case (clr_state_r)
        CLR_IDLE:
          if (|pending_r)
          begin
            o_off_clear.mask           <= serve_oh;
            o_off_clear.policing_value <= POLICING_RELOAD;
            clr_state_r                <= CLR_STROBE;
          end
        CLR_STROBE:
        begin
          o_off_clear <= '0;
          clr_state_r <= CLR_IDLE;
        end
        default:
        begin
          o_off_clear <= '0;
          clr_state_r <= CLR_IDLE;
        end
      endcase
    end

  // Age of outstanding clears, checked against the completion limit
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      pending_age_r <= 32'h0000_0000;
    else if (|pending_r)
      pending_age_r <= pending_age_r + 32'h0000_0001;
    else
      pending_age_r <= 32'h0000_0000;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_off_unpowered;
    1 |=> ((o_channel_on_flags & $past(off_mask)) == '0);
  endproperty
  a_off_unpowered: assert property (p_off_unpowered) else $error("channel on flag set in off mode");

  property p_pg_needs_on;
    (o_power_good_flags & ~o_channel_on_flags) == '0;
  endproperty
  a_pg_needs_on: assert property (p_pg_needs_on) else $error("power good set on an off channel");

  property p_pg_holds;
    ##1 (($past(o_power_good_flags) & o_channel_on_flags & ~o_power_good_flags) == '0);
  endproperty
  a_pg_holds: assert property (p_pg_holds) else $error("power good dropped while channel on");

  // The event pulse is registered at the same edge as the falling flag
  property p_pe_event;
    (o_channel_on_flags != '0) ##1 ((o_channel_on_flags & $past(o_channel_on_flags)) != $past(o_channel_on_flags))
      |-> (o_power_enable_change_event != '0);
  endproperty
  a_pe_event: assert property (p_pe_event) else $error("channel on fall gave no change event");

  property p_mode_write;
    mode_wr |=> ##1 (o_channel_mode == $past(wr.data, 2));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write not reflected");

  property p_ro_ignored;
    (wr.stb && (wr.cmd == CMD_POWER_STATE || wr.cmd == CMD_STRAP_READ)) |=> $stable(channel_mode_select_r);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write changed a register");

  property p_clear_single;
    $onehot0(o_off_clear.mask) && ((o_off_clear.mask != '0) -> (o_off_clear.policing_value == POLICING_RELOAD));
  endproperty
  a_clear_single: assert property (p_clear_single) else $error("bad off clear strobe");

  property p_clear_in_time;
    pending_age_r < OFF_CLEAR_LIMIT;
  endproperty
  a_clear_in_time: assert property (p_clear_in_time) else $error("off clear overdue");

  // Checked only at the capture, since the straps are not tracked afterwards
  property p_group_bit_b;
    ($rose(strap_caught_r) && $past(i_config_b)) |-> (address_strap_readback_r[GROUP_BIT] == 1'b0);
  endproperty
  a_group_bit_b: assert property (p_group_bit_b) else $error("group bit set in configuration B");

  property p_strap_reserved;
    address_strap_readback_r[7] == 1'b0 && address_strap_readback_r[1:0] == 2'h0;
  endproperty
  a_strap_reserved: assert property (p_strap_reserved) else $error("reserved strap bits set");

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_chk
    property p_entry_cleared;
      off_entry[ch] |-> ##[1:CLEAR_BOUND] o_off_clear.mask[ch];
    endproperty
    a_entry_cleared: assert property (p_entry_cleared) else $error("off entry not cleared in time");
  end

  c_off_entry:  cover property (off_entry != '0 ##[1:CLEAR_BOUND] o_off_clear.mask != '0);
  c_pg_latch:   cover property (o_power_good_flags != '0 ##1 o_power_good_change_event != '0);
  c_cool:       cover property (o_cooldown_cancel != '0);
  c_group_b:    cover property ($rose(strap_caught_r) && $past(i_config_b));

endmodule

/* tb/i2c_host_model.sv */
/*
  Host side of the serial command port: drives SCL and its share of SDA.
  Assumes an open-drain SDA with a pull-up and a target that pulls low via oe.
*/
`timescale 1ns/1ps

module i2c_host_model
(
  // Clock
  input  wire logic i_clk,
  // Target pull-down
  input  wire logic i_sda_oe,
  // Wire levels
  output logic      o_scl,
  output logic      o_sda
);
  logic sda_drv_r;

  // Wired-and: a released line is pulled high, never left at its last value
  assign o_sda = sda_drv_r & ~i_sda_oe;

  // Bus idle at time zero
  initial
  begin
    o_scl     = 1'b1;
    sda_drv_r = 1'b1;
  end

  // Step of four clocks; SCL stays high one step and low two, slow against the clock
  task automatic hc();
    repeat (4) @(posedge i_clk);
  endtask

  // Start, also usable as repeated start from SCL low
  task automatic start();
    sda_drv_r <= 1'b1;
    hc();
    o_scl     <= 1'b1;
    hc();
    sda_drv_r <= 1'b0;
    hc();
    o_scl     <= 1'b0;
    hc();
  endtask

  task automatic stop();
    sda_drv_r <= 1'b0;
    hc();
    o_scl     <= 1'b1;
    hc();
    sda_drv_r <= 1'b1;
    hc();
  endtask

  // One bit: data set while SCL low, sampled at the end of SCL high
  task automatic bit_io(input logic b, output logic r);
    sda_drv_r <= b;
    hc();
    o_scl     <= 1'b1;
    hc();
    r = o_sda;
    o_scl     <= 1'b0;
    hc();
  endtask

  // Eight bits MSB first, then the ninth bit (1 releases it to the target)
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(last, a);
    ack = ~a;
  endtask
endmodule

/* tb/pse_channel_status_mode_regs_tb_top.sv */
/*
  Self-checking bench for the channel status and mode registers.
  Assumes the host model drives the serial pins and power stage inputs are free.
*/
`timescale 1ns/1ps

module pse_channel_status_mode_regs_tb_top
  import pse_status_mode_pkg::*;
;
  logic             clk, rst_n, scl, sda, sda_oe, grp, cfgb, mark, ak, sdo;
  logic [3:0]       strap, ch_on, ton, drn, act, pg, on, pgc, pec, cc;
  logic [3:0]       seen_clr, seen_cc, seen_pgc, seen_pec, pg_e, on_e, pg_n, on_p;
  logic [7:0]       mode, v, d;
  logic [11:0]      r;
  logic [6:0]       dev;
  off_clear_t       oc;
  int               err_count, checked;

  // Target address from straps and effective group bit
  assign dev = {ADDR_TOP_BITS, strap, grp & ~cfgb};

  pse_channel_status_mode_regs #(.OFF_CLEAR_LIMIT(64)) dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sdo), .o_sda_oe(sda_oe),
    .i_strap_pins(strap), .i_group_select(grp), .i_config_b(cfgb), .i_channel_on(ch_on),
    .i_turn_on_active(ton), .i_drain_below_pg(drn), .o_channel_mode(mode), .o_channel_active(act),
    .o_power_good_flags(pg), .o_channel_on_flags(on), .o_power_good_change_event(pgc),
    .o_power_enable_change_event(pec), .o_cooldown_cancel(cc), .o_off_clear(oc));

  i2c_host_model host (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));

  always #10 clk = ~clk;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Pulses are short, so they are gathered between marks
  always @(posedge clk)
  begin
    seen_clr <= mark ? 4'h0 : seen_clr | oc.mask;
    seen_cc  <= mark ? 4'h0 : seen_cc | cc;
    seen_pgc <= mark ? 4'h0 : seen_pgc | pgc;
    seen_pec <= mark ? 4'h0 : seen_pec | pec;
    if (oc.mask != 4'h0)
      chk(oc.policing_value, POLICING_RELOAD);
    // Open drain: the data value must be low whenever the pin is driven
    if (sda_oe)
      chk({7'h0, sdo}, 8'h00);
  end

  task automatic do_mark();
    mark <= 1'b1;
    @(posedge clk);
    mark <= 1'b0;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] dt, output logic k);
    logic [7:0] q;
    logic       a1, a2, a3;
    host.start();
    host.byte_io({a, 1'b0}, 1'b1, q, a1);
    host.byte_io(c, 1'b1, q, a2);
    host.byte_io(dt, 1'b1, q, a3);
    host.stop();
    k = a1 & a2 & a3;
  endtask

  task automatic rd(input logic [7:0] c, output logic [7:0] q);
    logic [7:0] x;
    logic       a;
    host.start();
    host.byte_io({dev, 1'b0}, 1'b1, x, a);
    host.byte_io(c, 1'b1, x, a);
    host.start();
    host.byte_io({dev, 1'b1}, 1'b1, x, a);
    host.byte_io(8'hFF, 1'b1, q, a);
    host.stop();
  endtask

  function automatic logic [3:0] act_of(input logic [7:0] m);
    for (int i = 0; i < NUM_CH; i++)
      act_of[i] = (m[2*i +: 2] != MODE_OFF);
  endfunction

  task automatic summarize();
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'hbb2b));
    // Group bit high, so configuration B later has something to force low
    {clk, rst_n, grp, cfgb, mark, ch_on, ton, drn} = 17'h0_4000;
    {seen_clr, seen_cc, seen_pgc, seen_pec} = 16'h0000;
    {err_count, checked, pg_e, on_p} = 0;
    strap = 4'($urandom);
    do_reset();
    // Reset values, strap readback, unmapped read
    rd(CMD_STRAP_READ, d);
    chk(d, {1'b0, strap, 1'b1, 2'b00});
    rd(CMD_POWER_STATE, d);
    chk(d, POWER_STATE_RST);
    rd(CMD_MODE_SELECT, d);
    chk(d, MODE_SELECT_RST);
    rd(8'h13, d);
    chk(d, READ_UNMAPPED);
    // Read-only registers ignore writes; a foreign address is not answered
    wr(dev, CMD_POWER_STATE, 8'hA5, ak);
    wr(dev, CMD_STRAP_READ, 8'h5A, ak);
    rd(CMD_STRAP_READ, d);
    chk(d, {1'b0, strap, 1'b1, 2'b00});
    rd(CMD_POWER_STATE, d);
    chk(d, POWER_STATE_RST);
    wr(dev ^ 7'h04, CMD_MODE_SELECT, 8'hFF, ak);
    chk({7'h0, ak}, 8'h00);
    // Every mode code in every field, then random patterns
    for (int i = 0; i < 7; i++)
    begin
      v = (i < 4) ? {4{i[1:0]}} : 8'($urandom);
      wr(dev, CMD_MODE_SELECT, v, ak);
      rd(CMD_MODE_SELECT, d);
      chk(d, v);
      chk(mode, v);
      chk({4'h0, act}, {4'h0, act_of(v)});
    end
    // Broadcast write puts all channels in automatic mode
    wr(BROADCAST_ADDR, CMD_MODE_SELECT, 8'hFF, ak);
    chk({7'h0, ak}, 8'h01);
    chk(mode, 8'hFF);
    // Power stage changes: flags, latching power-good, falling-edge events
    for (int i = 0; i < 9; i++)
    begin
      r = (i == 0) ? 12'hFFF : (i == 1) ? 12'hF00 : (i == 8) ? 12'hFFF : 12'($urandom);
      do_mark();
      {ch_on, ton, drn} <= r;
      on_e = r[11:8];
      pg_n = on_e & (pg_e | (r[7:4] & r[3:0]));
      repeat (4) @(posedge clk);
      chk({pg, on}, {pg_n, on_e});
      chk({seen_pgc, seen_pec}, {pg_e & ~pg_n, on_p & ~on_e});
      pg_e = pg_n;
      on_p = on_e;
      rd(CMD_POWER_STATE, d);
      chk(d, {pg_n, on_e});
    end
    // Off entry from semi and a move to manual, two channels left running
    wr(dev, CMD_MODE_SELECT, 8'hAA, ak);
    do_mark();
    wr(dev, CMD_MODE_SELECT, 8'h48, ak);
    repeat (4) @(posedge clk);
    chk({4'h0, seen_clr}, 8'h05);
    chk({4'h0, seen_cc}, 8'h0D);
    chk({pg, on}, 8'hAA);
    chk({seen_pgc, seen_pec}, 8'h55);
    // Configuration B forces the group bit low
    cfgb <= 1'b1;
    do_reset();
    rd(CMD_STRAP_READ, d);
    chk(d, {1'b0, strap, 3'b000});
    summarize();
  end
endmodule
